// ---- design/cpu_bus_cycle_sequencer.sv ----
/*
 * Bus-cycle sequencer of an 8-bit accumulator CPU decoder: runs a given
 * sequence of per-cycle bus actions and forms operand addresses.
 * Assumes memory answers a read within the cycle its address is shown,
 * and that the datapath supplies write data one cycle ahead.
 */
// Contract
// - free cycle needs no bus, lasts one clock, is a read
// - fetch reads next program location and advances program counter
// - operand read takes one byte in one bus cycle
// - operand write stores one byte in one bus cycle
// - push writes one byte at stack pointer
// - pop reads one byte back from the stack
// - vector read from page FF, high byte first
// - indexed, no offset: index pair is the address
// - indexed with byte offset, index incremented afterwards; code increments it only after a read cycle, not after a write
// - stack pointer plus unsigned byte offset
// - stack pointer plus 16-bit offset
// - index pair plus 16-bit offset
// - branch adds one offset byte to program counter
// - branch offset is signed, reach -128 to +127
`timescale 1ns/100ps
module cpu_bus_cycle_sequencer #(
    parameter int SEQ_MAX = seq_pkg::SEQ_MAX
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Instruction request from the opcode decoder
    input wire logic start_i,
    input wire seq_pkg::cycle_t [SEQ_MAX-1:0] seq_i,
    input wire logic [seq_pkg::LEN_W-1:0] seq_len_i,
    input wire seq_pkg::mode_t mode_i,
    input wire logic branch_taken_i,
    input wire logic [7:0] vector_lo_i,
    // Datapath data
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_i,
    // System bus
    output logic [15:0] addr_o,
    output logic read_o,
    output logic bus_need_o,
    output seq_pkg::cycle_t cycle_o,
    output logic [7:0] wdata_o,
    // Read results and status
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic busy_o,
    output logic done_o,
    // Pointer registers
    output logic [15:0] pc_o,
    output logic [15:0] sp_o,
    output logic [15:0] hx_o
);

    seq_pkg::state_t state_r, state_nxt;
    seq_pkg::cycle_t [SEQ_MAX-1:0] seq_r, seq_nxt;
    logic [seq_pkg::LEN_W-1:0] len_r, len_nxt, step_r, step_nxt;
    seq_pkg::mode_t mode_r, mode_nxt;
    logic taken_r, taken_nxt;
    logic [7:0] vec_lo_r, vec_lo_nxt, vec_hi_r, vec_hi_nxt;
    logic vec_second_r, vec_second_nxt;
    logic [1:0] opr_cnt_r, opr_cnt_nxt;
    logic [15:0] opr_r, opr_nxt;
    logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt, hx_r, hx_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic read_r, read_nxt, need_r, need_nxt;
    seq_pkg::cycle_t cyc_r, cyc_nxt;
    logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt, done_r, done_nxt;
    logic [15:0] pc_c, sp_c, hx_c, opr_c;
    logic [1:0] opr_need;
    logic [15:0] ea;
    logic issue;
    seq_pkg::cycle_t next_cyc;

    // Address former for read and write cycles
    ea_calc u_ea (
        .mode_i(seq_pkg::mode_t'((state_r == seq_pkg::ST_IDLE) ? mode_i : mode_r)),
        .hx_i(hx_c),
        .sp_i(sp_c),
        .opr_i(opr_c),
        .ea_o(ea)
    );

    // Operand bytes the addressing form takes from the stream
    always_comb begin
        unique case (mode_r)
            seq_pkg::immediate_mode, seq_pkg::direct_mode, seq_pkg::relative_mode,
            seq_pkg::index_short_offset_mode, seq_pkg::index_short_offset_postinc_mode,
            seq_pkg::stack_short_offset_mode: opr_need = 2'd1;
            seq_pkg::extended_mode, seq_pkg::index_long_offset_mode,
            seq_pkg::stack_long_offset_mode: opr_need = 2'd2;
            default: opr_need = 2'd0;
        endcase
    end

    // Completion of the cycle now on the bus
    always_comb begin
        pc_c = pc_r;
        sp_c = sp_r;
        hx_c = hx_r;
        opr_c = opr_r;
        opr_cnt_nxt = opr_cnt_r;
        vec_hi_nxt = vec_hi_r;
        vec_second_nxt = vec_second_r;
        rvalid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        if (state_r == seq_pkg::ST_RUN) begin
            if (read_r && need_r) begin
                rdata_nxt = rdata_i;
                rvalid_nxt = 1'b1;
            end
            unique case (cyc_r)
                seq_pkg::CYC_FETCH: begin
                    if (opr_cnt_r < opr_need) begin
                        opr_c = {opr_r[7:0], rdata_i};
                        opr_cnt_nxt = opr_cnt_r + 2'd1;
                    end
                end
                seq_pkg::CYC_READ: begin
                    if (mode_r == seq_pkg::index_no_offset_postinc_mode ||
                        mode_r == seq_pkg::index_short_offset_postinc_mode) begin
                        hx_c = hx_r + seq_pkg::INDEX_STEP;
                    end
                end
                seq_pkg::CYC_VECTOR: begin
                    if (!vec_second_r) begin
                        vec_hi_nxt = rdata_i;
                        vec_second_nxt = 1'b1;
                    end else begin
                        pc_c = {vec_hi_r, rdata_i};
                        vec_second_nxt = 1'b0;
                    end
                end
                default: ;
            endcase
            if (step_r + 4'd1 >= len_r) begin
                done_nxt = 1'b1;
                if (mode_r == seq_pkg::relative_mode && taken_r) begin
                    // Sign-extended offset from the start of the next instruction
                    pc_c = pc_c + {{8{opr_c[7]}}, opr_c[7:0]};
                end
            end
        end
    end

    // Issue of the next bus cycle
    always_comb begin
        state_nxt = state_r;
        seq_nxt = seq_r;
        len_nxt = len_r;
        step_nxt = step_r;
        mode_nxt = mode_r;
        taken_nxt = taken_r;
        vec_lo_nxt = vec_lo_r;
        opr_nxt = opr_c;
        pc_nxt = pc_c;
        sp_nxt = sp_c;
        hx_nxt = hx_c;
        addr_nxt = addr_r;
        read_nxt = 1'b1;
        need_nxt = 1'b0;
        cyc_nxt = seq_pkg::CYC_FREE;
        wdata_nxt = wdata_r;
        issue = 1'b0;
        next_cyc = seq_pkg::CYC_FREE;
        if (state_r == seq_pkg::ST_IDLE) begin
            if (start_i && seq_len_i != '0) begin
                state_nxt = seq_pkg::ST_RUN;
                seq_nxt = seq_i;
                len_nxt = seq_len_i;
                step_nxt = '0;
                mode_nxt = mode_i;
                taken_nxt = branch_taken_i;
                vec_lo_nxt = vector_lo_i;
                opr_nxt = '0;
                issue = 1'b1;
                next_cyc = seq_i[0];
            end
        end else if (done_nxt) begin
            state_nxt = seq_pkg::ST_IDLE;
        end else begin
            step_nxt = step_r + 4'd1;
            issue = 1'b1;
            next_cyc = seq_r[step_r + 4'd1];
        end
        if (issue) begin
            cyc_nxt = next_cyc;
            unique case (next_cyc)
                seq_pkg::CYC_FREE: begin
                    addr_nxt = pc_c;
                end
                seq_pkg::CYC_FETCH: begin
                    addr_nxt = pc_c;
                    pc_nxt = pc_c + 16'h0001;
                    need_nxt = 1'b1;
                end
                seq_pkg::CYC_READ: begin
                    addr_nxt = ea;
                    need_nxt = 1'b1;
                end
                seq_pkg::CYC_WRITE: begin
                    addr_nxt = ea;
                    read_nxt = 1'b0;
                    need_nxt = 1'b1;
                    wdata_nxt = wdata_i;
                end
                seq_pkg::CYC_PUSH: begin
                    addr_nxt = sp_c;
                    sp_nxt = sp_c - seq_pkg::STACK_STEP;
                    read_nxt = 1'b0;
                    need_nxt = 1'b1;
                    wdata_nxt = wdata_i;
                end
                seq_pkg::CYC_POP: begin
                    sp_nxt = sp_c + seq_pkg::STACK_STEP;
                    addr_nxt = sp_c + seq_pkg::STACK_STEP;
                    need_nxt = 1'b1;
                end
                seq_pkg::CYC_VECTOR: begin
                    // High byte sits at the lower address and is read first
                    addr_nxt = {seq_pkg::VECTOR_PAGE,
                                vec_second_nxt ? vec_lo_nxt + 8'h01 : vec_lo_nxt};
                    need_nxt = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= seq_pkg::ST_IDLE;
            seq_r <= '{default: seq_pkg::CYC_FREE};
            len_r <= '0;
            step_r <= '0;
            mode_r <= seq_pkg::inherent_mode;
            taken_r <= 1'b0;
            vec_lo_r <= 8'h00;
            vec_hi_r <= 8'h00;
            vec_second_r <= 1'b0;
            opr_cnt_r <= 2'd0;
            opr_r <= 16'h0000;
            pc_r <= seq_pkg::PC_RESET;
            sp_r <= seq_pkg::SP_RESET;
            hx_r <= seq_pkg::HX_RESET;
            addr_r <= 16'h0000;
            read_r <= 1'b1;
            need_r <= 1'b0;
            cyc_r <= seq_pkg::CYC_FREE;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            seq_r <= seq_nxt;
            len_r <= len_nxt;
            step_r <= step_nxt;
            mode_r <= mode_nxt;
            taken_r <= taken_nxt;
            vec_lo_r <= vec_lo_nxt;
            vec_hi_r <= vec_hi_nxt;
            vec_second_r <= vec_second_nxt;
            opr_cnt_r <= (state_r == seq_pkg::ST_IDLE) ? 2'd0 : opr_cnt_nxt;
            opr_r <= opr_nxt;
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            hx_r <= hx_nxt;
            addr_r <= addr_nxt;
            read_r <= read_nxt;
            need_r <= need_nxt;
            cyc_r <= cyc_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            done_r <= done_nxt;
        end
    end

    // Outputs straight from flops
    assign addr_o = addr_r;
    assign read_o = read_r;
    assign bus_need_o = need_r;
    assign cycle_o = cyc_r;
    assign wdata_o = wdata_r;
    assign rdata_o = rdata_r;
    assign rdata_valid_o = rvalid_r;
    assign busy_o = (state_r == seq_pkg::ST_RUN);
    assign done_o = done_r;
    assign pc_o = pc_r;
    assign sp_o = sp_r;
    assign hx_o = hx_r;

endmodule // cpu_bus_cycle_sequencer

// ---- design/seq_pkg.sv ----
/*
 * Shared types and constants for the bus-cycle sequencer: cycle codes,
 * operand addressing forms, widths and values after reset.
 * Assumes an 8-bit data bus, a 16-bit address bus and one cycle per bus cycle.
 */
package seq_pkg;

    // Widths of the buses and of the sequence descriptor
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int SEQ_MAX = 11;
    localparam int LEN_W = 4;

    // Values after reset
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [15:0] HX_RESET = 16'h0000;

    // Top page that holds the service routine addresses
    localparam logic [7:0] VECTOR_PAGE = 8'hFF;
    // Index step of the post-increment forms
    localparam logic [15:0] INDEX_STEP = 16'h0001;
    // Stack step of one push or pop
    localparam logic [15:0] STACK_STEP = 16'h0001;
    // Page of the direct form
    localparam logic [7:0] DIRECT_PAGE = 8'h00;

    // Per-cycle bus actions
    typedef enum logic [2:0] {
        CYC_FREE,
        CYC_FETCH,
        CYC_READ,
        CYC_WRITE,
        CYC_PUSH,
        CYC_POP,
        CYC_VECTOR
    } cycle_t;

    // Operand addressing forms
    typedef enum logic [3:0] {
        inherent_mode,
        immediate_mode,
        direct_mode,
        extended_mode,
        relative_mode,
        index_no_offset_mode,
        index_short_offset_mode,
        index_long_offset_mode,
        index_no_offset_postinc_mode,
        index_short_offset_postinc_mode,
        stack_short_offset_mode,
        stack_long_offset_mode
    } mode_t;

    // Sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } state_t;

endpackage

// ---- design/ea_calc.sv ----
/*
 * Effective address former for the operand addressing forms.
 * Assumes the operand bytes were gathered high byte first into a 16-bit word.
 */
`timescale 1ns/100ps
module ea_calc (
    // Addressing form and base registers
    input wire seq_pkg::mode_t mode_i,
    input wire logic [15:0] hx_i,
    input wire logic [15:0] sp_i,
    // Operand bytes from the instruction stream
    input wire logic [15:0] opr_i,
    // Effective address
    output logic [15:0] ea_o
);

    // Form the address from base and offset
    always_comb begin
        unique case (mode_i)
            seq_pkg::direct_mode: ea_o = {seq_pkg::DIRECT_PAGE, opr_i[7:0]};
            seq_pkg::extended_mode: ea_o = opr_i;
            seq_pkg::index_no_offset_mode,
            seq_pkg::index_no_offset_postinc_mode: ea_o = hx_i;
            seq_pkg::index_short_offset_mode,
            seq_pkg::index_short_offset_postinc_mode: ea_o = hx_i + {8'h00, opr_i[7:0]};
            seq_pkg::index_long_offset_mode: ea_o = hx_i + opr_i;
            seq_pkg::stack_short_offset_mode: ea_o = sp_i + {8'h00, opr_i[7:0]};
            seq_pkg::stack_long_offset_mode: ea_o = sp_i + opr_i;
            default: ea_o = opr_i;
        endcase
    end

endmodule // ea_calc

// ---- sim/cpu_bus_cycle_sequencer_props.sv ----
/*
 * Port checker for the bus-cycle sequencer, bound to its top module.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/100ps
module cpu_bus_cycle_sequencer_props (
    // Clock, reset and request
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic [seq_pkg::LEN_W-1:0] seq_len_i,
    // Bus and status
    input wire logic [15:0] addr_o,
    input wire logic read_o,
    input wire logic bus_need_o,
    input wire seq_pkg::cycle_t cycle_o,
    input wire logic rdata_valid_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [15:0] pc_o,
    input wire logic [15:0] sp_o
);
    logic [3:0] len_r;
    logic [3:0] cnt_r;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // Length of the accepted sequence and busy cycles counted since
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            len_r <= 4'h0;
            cnt_r <= 4'h0;
        end else if (start_i && !busy_o && seq_len_i != 4'h0) begin
            len_r <= seq_len_i;
            cnt_r <= 4'h0;
        end else if (busy_o) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    a_free_is_read: assert property (cycle_o == seq_pkg::CYC_FREE |-> read_o && !bus_need_o)
        else $error("free cycle used the bus or wrote");
    a_fetch_adv_pc: assert property (cycle_o == seq_pkg::CYC_FETCH |-> pc_o == addr_o + 16'h0001)
        else $error("fetch did not advance the program counter");
    a_read_one_cycle: assert property (cycle_o == seq_pkg::CYC_READ |-> read_o ##1 rdata_valid_o)
        else $error("operand read gave no data a cycle later");
    a_write_uses_bus: assert property (cycle_o == seq_pkg::CYC_WRITE |-> !read_o && bus_need_o)
        else $error("operand write not a bus write");
    a_pop_at_sp: assert property (cycle_o == seq_pkg::CYC_POP |-> read_o && addr_o == sp_o)
        else $error("pop address is not the stack pointer");
    a_push_at_sp: assert property (cycle_o == seq_pkg::CYC_PUSH |-> !read_o && bus_need_o && addr_o == sp_o + 16'h0001)
        else $error("push address is not the stack pointer");
    a_vector_top_page: assert property (cycle_o == seq_pkg::CYC_VECTOR |-> addr_o[15:8] == 8'hFF)
        else $error("vector read outside the top page");
    a_start_taken: assert property (start_i && !busy_o && seq_len_i != 4'h0 |=> busy_o)
        else $error("accepted start did not raise busy");
    a_done_ends_busy: assert property (done_o |-> !busy_o && $past(busy_o))
        else $error("done without a preceding busy run");
    a_seq_length: assert property (done_o |-> cnt_r == len_r)
        else $error("sequence length differs from the request");
    c_done: cover property (done_o);
    c_vector: cover property (cycle_o == seq_pkg::CYC_VECTOR);
    c_push: cover property (cycle_o == seq_pkg::CYC_PUSH);
endmodule // cpu_bus_cycle_sequencer_props

bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_props props_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .start_i(start_i), .seq_len_i(seq_len_i),
    .addr_o(addr_o), .read_o(read_o), .bus_need_o(bus_need_o), .cycle_o(cycle_o),
    .rdata_valid_o(rdata_valid_o), .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o),
    .sp_o(sp_o)
);

// ---- sim/bus_memory_model.sv ----
/*
 * Behavioural program and data memory on the system bus side.
 * Assumes a read is answered within the cycle its address is shown.
 */
`timescale 1ns/100ps
module bus_memory_model (
    // Clock
    input wire logic clock_i,
    // Bus from the sequencer
    input wire logic [15:0] addr_i,
    input wire logic read_i,
    input wire logic need_i,
    input wire logic [7:0] wdata_i,
    // Read data back
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // Stores writes and remembers the last byte handed out
    always @(posedge clock_i) begin
        if (need_i && !read_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (need_i && read_i) begin
            last_r <= rdata_o;
        end
    end
    // Unused bus shows the inverse of the last byte, never a stale copy
    assign rdata_o = (need_i && read_i) ? mem[addr_i] : ~last_r;
endmodule // bus_memory_model

// ---- sim/cpu_bus_cycle_sequencer_bench.sv ----
/*
 * Self-checking bench for the bus-cycle sequencer with a memory model.
 * Assumes the package constants and a 100 MHz clock.
 */
`timescale 1ns/100ps
module cpu_bus_cycle_sequencer_bench;
    logic clock_i, arst_n_i, start_i, branch_taken_i, read_o, bus_need_o;
    logic rdata_valid_o, busy_o, done_o;
    seq_pkg::cycle_t [seq_pkg::SEQ_MAX-1:0] seq_i;
    seq_pkg::cycle_t cycle_o;
    seq_pkg::mode_t mode_i;
    logic [3:0] seq_len_i;
    logic [7:0] vector_lo_i, wdata_i, rdata_i, wdata_o, rdata_o;
    logic [15:0] addr_o, pc_o, sp_o, hx_o, pc_exp;
    int error_cnt = 0;
    int comparisons = 0;

    cpu_bus_cycle_sequencer dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .start_i(start_i),
        .seq_i(seq_i), .seq_len_i(seq_len_i), .mode_i(mode_i), .branch_taken_i(branch_taken_i),
        .vector_lo_i(vector_lo_i), .wdata_i(wdata_i), .rdata_i(rdata_i), .addr_o(addr_o),
        .read_o(read_o), .bus_need_o(bus_need_o), .cycle_o(cycle_o), .wdata_o(wdata_o),
        .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .busy_o(busy_o), .done_o(done_o),
        .pc_o(pc_o), .sp_o(sp_o), .hx_o(hx_o));
    bus_memory_model mem_u (.clock_i(clock_i), .addr_i(addr_o), .read_i(read_o),
        .need_i(bus_need_o), .wdata_i(wdata_o), .rdata_o(rdata_i));

    // Clock generator
    always #5 clock_i = ~clock_i;

    task automatic complete_run();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Issues one sequence and waits a bounded time for its done pulse
    task automatic run(input seq_pkg::cycle_t s[3], input int n, input seq_pkg::mode_t m);
        seq_pkg::cycle_t [seq_pkg::SEQ_MAX-1:0] v;
        int k;
        for (int i = 0; i < seq_pkg::SEQ_MAX; i++) begin
            v[i] = (i < 3) ? s[i] : seq_pkg::CYC_FREE;
        end
        @(posedge clock_i);
        start_i <= 1'b1;
        seq_i <= v;
        seq_len_i <= 4'(n);
        mode_i <= m;
        @(posedge clock_i);
        start_i <= 1'b0;
        k = 0;
        while (done_o !== 1'b1 && k < 20) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        if (done_o !== 1'b1) begin
            error_cnt++;
            complete_run();
        end else begin
            check(16'(k), 16'(n));
        end
    endtask

    // Operand fetches then one read at the expected effective address
    task automatic rd(input seq_pkg::mode_t m, input int nb, input logic [15:0] opr,
        input logic [15:0] ea);
        seq_pkg::cycle_t s[3];
        s = '{seq_pkg::CYC_FETCH, seq_pkg::CYC_FETCH, seq_pkg::CYC_FREE};
        s[nb] = seq_pkg::CYC_READ;
        mem_u.mem[pc_exp] = (nb == 2) ? opr[15:8] : opr[7:0];
        mem_u.mem[pc_exp + 16'h0001] = opr[7:0];
        mem_u.mem[ea] = ea[7:0] ^ 8'h3C;
        pc_exp = pc_exp + 16'(nb);
        run(s, nb + 1, m);
        check({8'h00, rdata_o}, {8'h00, ea[7:0] ^ 8'h3C});
        check(pc_o, pc_exp);
    endtask

    task automatic vector_branch();
        mem_u.mem[16'hFF10] = 8'h01;
        mem_u.mem[16'hFF11] = 8'h00;
        mem_u.mem[16'h0100] = 8'h80;
        mem_u.mem[16'h0081] = 8'h7F;
        @(posedge clock_i);
        vector_lo_i <= 8'h10;
        run('{seq_pkg::CYC_VECTOR, seq_pkg::CYC_VECTOR, seq_pkg::CYC_FREE}, 2,
            seq_pkg::inherent_mode);
        check(pc_o, 16'h0100);
        @(posedge clock_i);
        branch_taken_i <= 1'b1;
        run('{seq_pkg::CYC_FETCH, seq_pkg::CYC_FREE, seq_pkg::CYC_FREE}, 2,
            seq_pkg::relative_mode);
        check(pc_o, 16'h0081);
        run('{seq_pkg::CYC_FETCH, seq_pkg::CYC_FREE, seq_pkg::CYC_FREE}, 2,
            seq_pkg::relative_mode);
        check(pc_o, 16'h0101);
        @(posedge clock_i);
        branch_taken_i <= 1'b0;
        // Branch not taken: only the offset fetch advances the program counter
        mem_u.mem[16'h0101] = 8'h80;
        run('{seq_pkg::CYC_FETCH, seq_pkg::CYC_FREE, seq_pkg::CYC_FREE}, 2,
            seq_pkg::relative_mode);
        check(pc_o, 16'h0102);
        pc_exp = 16'h0102;
    endtask

    task automatic address_forms();
        rd(seq_pkg::index_no_offset_mode, 0, 16'h0000, 16'h0000);
        rd(seq_pkg::index_short_offset_postinc_mode, 1, 16'h0020, 16'h0020);
        check(hx_o, 16'h0001);
        rd(seq_pkg::index_long_offset_mode, 2, 16'h3000, 16'h3001);
        rd(seq_pkg::stack_short_offset_mode, 1, 16'h0080, 16'h017F);
        rd(seq_pkg::stack_long_offset_mode, 2, 16'h2000, 16'h20FF);
        rd(seq_pkg::extended_mode, 2, 16'h4000, 16'h4000);
        rd(seq_pkg::direct_mode, 1, 16'h0044, 16'h0044);
        rd(seq_pkg::index_no_offset_postinc_mode, 0, 16'h0000, 16'h0001);
        check(hx_o, 16'h0002);
        rd(seq_pkg::index_short_offset_mode, 1, 16'h0010, 16'h0012);
        check(hx_o, 16'h0002);
    endtask

    task automatic write_stack();
        mem_u.mem[pc_exp] = 8'h50;
        mem_u.mem[pc_exp + 16'h0001] = 8'h00;
        pc_exp = pc_exp + 16'h0002;
        @(posedge clock_i);
        wdata_i <= 8'hC3;
        run('{seq_pkg::CYC_FETCH, seq_pkg::CYC_FETCH, seq_pkg::CYC_WRITE}, 3,
            seq_pkg::extended_mode);
        check({8'h00, mem_u.mem[16'h5000]}, 16'h00C3);
        @(posedge clock_i);
        wdata_i <= 8'h96;
        run('{seq_pkg::CYC_PUSH, seq_pkg::CYC_FREE, seq_pkg::CYC_FREE}, 1,
            seq_pkg::inherent_mode);
        check({8'h00, mem_u.mem[16'h00FF]}, 16'h0096);
        check(sp_o, 16'h00FE);
        run('{seq_pkg::CYC_POP, seq_pkg::CYC_FREE, seq_pkg::CYC_FREE}, 1,
            seq_pkg::inherent_mode);
        check({8'h00, rdata_o}, 16'h0096);
        check(sp_o, 16'h00FF);
    endtask

    task automatic free_cycles();
        run('{seq_pkg::CYC_FREE, seq_pkg::CYC_FREE, seq_pkg::CYC_FREE}, 3,
            seq_pkg::inherent_mode);
        check(pc_o, pc_exp);
    endtask

    // Reset, reset values, then the scenarios
    initial begin
        clock_i = 1'b0;
        arst_n_i = 1'b0;
        start_i = 1'b0;
        for (int i = 0; i < seq_pkg::SEQ_MAX; i++) begin
            seq_i[i] = seq_pkg::CYC_FREE;
        end
        seq_len_i = 4'h0;
        mode_i = seq_pkg::inherent_mode;
        branch_taken_i = 1'b0;
        vector_lo_i = 8'h00;
        wdata_i = 8'h00;
        repeat (10) @(posedge clock_i);
        check(sp_o, 16'h00FF);
        check(hx_o, 16'h0000);
        arst_n_i <= 1'b1;
        vector_branch();
        address_forms();
        write_stack();
        free_cycles();
        complete_run();
    end
endmodule // cpu_bus_cycle_sequencer_bench
